//--- rtl/scan_ctrl_defines.svh
`ifndef SCAN_CTRL_DEFINES_SVH
`define SCAN_CTRL_DEFINES_SVH

// printed offsets are 0x0, 0x1, 0x2 and 0x9 (not all multiples of four), so each is an index
`define IDX_SOFT_STROBE   4'h0
`define IDX_RANGE_SELECT  4'h1
`define IDX_SCAN_LIMITS   4'h2
`define IDX_TRIG_CONTROL  4'h9
`define IDX_RANGE_READ    4'ha

// trigger source encoding in the two low bits of the control word
`define TRIG_SRC_SOFT     2'h1
`define TRIG_SRC_PACER    2'h2
`define TRIG_SRC_EXT      2'h3

// field positions
`define RANGE_LSB         0
`define START_LSB         0
`define STOP_LSB          4
`define SRC_LSB           0

// reset values
`define RANGE_RESET       4'h0
`define CHANNEL_RESET     4'h0
`define SRC_RESET         2'h0

// timing counts
`define CONV_PULSE_CYCLES 4'h1

`endif

//--- rtl/scan_ctrl_pkg.sv
package scan_ctrl_pkg;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SOFT,
    SRC_PACER,
    SRC_EXT
  } trig_src_t;

  typedef enum logic [1:0] {
    RANGE_BIPOLAR,
    RANGE_UNIPOLAR,
    RANGE_UNUSED
  } range_kind_t;

  typedef logic [3:0] channel_t;

endpackage

//--- rtl/range_store.sv
`timescale 1ns/1ns
`include "scan_ctrl_defines.svh"

module range_store #(
  parameter int CHANNELS = 16,
  parameter int CODE_W   = 4
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         wr_en_in,
  input  wire logic [$clog2(CHANNELS)-1:0]  wr_addr_in,
  input  wire logic [CODE_W-1:0]            wr_data_in,
  input  wire logic [$clog2(CHANNELS)-1:0]  rd_addr_in,
  output logic      [CODE_W-1:0]            rd_data_out
);

  logic [CODE_W-1:0] code_mem [CHANNELS];

  //////////////////////////////////////////////////////////////////////////////
  // one code per channel, cleared at reset
  genvar g;
  for (g = 0; g < CHANNELS; g++) begin : g_entry
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        code_mem[g] <= `RANGE_RESET;
      end else if (wr_en_in && (wr_addr_in == ($clog2(CHANNELS))'(g))) begin
        code_mem[g] <= wr_data_in;
      end
    end
  end

  assign rd_data_out = code_mem[rd_addr_in];

endmodule

//--- rtl/adc_trigger_range_scan_ctrl.sv
// What this block does
// - With software triggering selected, any write to the strobe register starts one conversion.
// - The trigger source comes from the two low bits of the control register at index 0x9.
// - Conversions start from software, the pacer or the external pulse, only from the selected one.
// - Each channel keeps its own 4-bit range code and the converted channel's code is applied.
// - A write to index 0x1 stores bits 3..0 as one channel's range code and ignores bits 7..4.
// - Range codes decode to bipolar, unipolar or unused spans per the gain variant.
// - A write to index 0x2 takes bits 7..4 as stop channel and bits 3..0 as start channel.
// - Every scan register write loads the current channel with the new start channel.
// - Each conversion start pulse without a scan register write in the same cycle advances the current channel to the next in the scan.
// - The channel steps from start up to stop and then returns to start.
// - Range code writes are addressed by the start channel field.
// - Selecting a channel for range programming changes the active start and stop channels.
// - A read of index 0x2 returns the current channel in bits 3..0.
`timescale 1ns/1ns
`include "scan_ctrl_defines.svh"

module adc_trigger_range_scan_ctrl #(
  parameter int  CHANNELS   = 16,
  parameter int  CODE_W     = 4,
  parameter bit  HIGH_GAIN  = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // trigger sources
  input  wire logic        pacer_tick_in,
  input  wire logic        ext_trigger_in,
  // converter side
  output logic             conv_start_out,
  output logic [3:0]       mux_channel_out,
  output logic [3:0]       range_code_out,
  output logic             range_bipolar_out,
  output logic             range_valid_out
);

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        addr_phase;
  logic        wr_pending_reg;
  logic [3:0]  wr_index_reg;
  logic        wr_soft;
  logic        wr_range;
  logic        wr_scan;
  logic        wr_ctrl;
  logic [7:0]  wr_byte;
  logic [3:0]  rd_index;
  logic        ext_prev_reg;

  assign addr_phase = hsel_in && hready_in && htrans_in[1];
  assign wr_byte    = hwdata_in[7:0];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pending_reg <= 1'b0;
      wr_index_reg   <= 4'h0;
    end else begin
      wr_pending_reg <= addr_phase && hwrite_in && (haddr_in[31:6] == 26'h0)
                        && (haddr_in[1:0] == 2'h0);
      wr_index_reg   <= haddr_in[5:2];
    end
  end

  assign wr_soft  = wr_pending_reg && (wr_index_reg == `IDX_SOFT_STROBE);
  assign wr_range = wr_pending_reg && (wr_index_reg == `IDX_RANGE_SELECT);
  assign wr_scan  = wr_pending_reg && (wr_index_reg == `IDX_SCAN_LIMITS);
  assign wr_ctrl  = wr_pending_reg && (wr_index_reg == `IDX_TRIG_CONTROL);

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // trigger source select

  logic [1:0]  trig_src_reg;
  logic        trigger;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trig_src_reg <= `SRC_RESET;
    end else if (wr_ctrl) begin
      trig_src_reg <= wr_byte[`SRC_LSB +: 2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_trigger_in;
    end
  end

  always_comb begin
    case (trig_src_reg)
      `TRIG_SRC_SOFT:  trigger = wr_soft;
      `TRIG_SRC_PACER: trigger = pacer_tick_in;
      `TRIG_SRC_EXT:   trigger = ext_trigger_in && !ext_prev_reg;
      default:         trigger = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= trigger;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan sequencer

  logic [3:0]  start_reg;
  logic [3:0]  stop_reg;
  logic [3:0]  current_reg;
  logic [3:0]  current_next;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_reg <= `CHANNEL_RESET;
      stop_reg  <= `CHANNEL_RESET;
    end else if (wr_scan) begin
      stop_reg  <= wr_byte[`STOP_LSB +: 4];
      start_reg <= wr_byte[`START_LSB +: 4];
    end
  end

  always_comb begin
    if (current_reg == stop_reg) begin
      current_next = start_reg;
    end else begin
      current_next = current_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      current_reg <= `CHANNEL_RESET;
    end else if (wr_scan) begin
      current_reg <= wr_byte[`START_LSB +: 4];
    end else if (conv_start_out) begin
      current_reg <= current_next;
    end
  end

  assign mux_channel_out = current_reg;

  //////////////////////////////////////////////////////////////////////////////
  // range code storage

  logic [CODE_W-1:0] code_rd;

  range_store #(
    .CHANNELS (CHANNELS),
    .CODE_W   (CODE_W)
  ) u_range_store (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (wr_range),
    .wr_addr_in  (start_reg),
    .wr_data_in  (wr_byte[`RANGE_LSB +: CODE_W]),
    .rd_addr_in  (current_reg),
    .rd_data_out (code_rd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // range decode

  scan_ctrl_pkg::range_kind_t kind;

  always_comb begin
    case (code_rd[3:2])
      2'h0:    kind = scan_ctrl_pkg::RANGE_BIPOLAR;
      2'h1:    kind = scan_ctrl_pkg::RANGE_UNIPOLAR;
      2'h2: begin
        if (code_rd[1:0] == 2'h0 || HIGH_GAIN) begin
          kind = scan_ctrl_pkg::RANGE_BIPOLAR;
        end else begin
          kind = scan_ctrl_pkg::RANGE_UNUSED;
        end
      end
      default: kind = scan_ctrl_pkg::RANGE_UNUSED;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      range_code_out    <= `RANGE_RESET;
      range_bipolar_out <= 1'b0;
      range_valid_out   <= 1'b0;
    end else begin
      range_code_out    <= code_rd;
      range_bipolar_out <= (kind == scan_ctrl_pkg::RANGE_BIPOLAR);
      range_valid_out   <= (kind != scan_ctrl_pkg::RANGE_UNUSED);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  logic        rd_pending_reg;
  logic [3:0]  rd_index_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pending_reg <= 1'b0;
      rd_index_reg   <= 4'h0;
    end else begin
      rd_pending_reg <= addr_phase && !hwrite_in;
      rd_index_reg   <= haddr_in[5:2];
    end
  end

  assign rd_index = rd_index_reg;

  always_comb begin
    hrdata_out = 32'h0;
    if (rd_pending_reg) begin
      case (rd_index)
        `IDX_SCAN_LIMITS:  hrdata_out = {28'h0, current_reg};
        `IDX_TRIG_CONTROL: hrdata_out = {30'h0, trig_src_reg};
        `IDX_RANGE_READ:   hrdata_out = {28'h0, code_rd};
        default:           hrdata_out = 32'h0;
      endcase
    end
  end

endmodule

//--- bench/conv_model.sv
`timescale 1ns/1ns
module conv_model (
  input  wire logic       clk_in,
  input  wire logic       conv_start_in,
  input  wire logic [3:0] chan_in,
  output int              count_out,
  output logic      [3:0] chan_out
);
  initial count_out = 0;
  // converts the channel the mux shows at each start pulse
  always @(posedge clk_in) begin
    if (conv_start_in === 1'b1) begin
      count_out <= count_out + 1;
      chan_out <= chan_in;
    end
  end
endmodule

//--- bench/scan_ctrl_checker_sva.sv
`timescale 1ns/1ns
module scan_ctrl_checker #(
  parameter bit HIGH_GAIN = 1'b0
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        conv_start_out,
  input wire logic [3:0]  mux_channel_out,
  input wire logic [3:0]  range_code_out,
  input wire logic        range_bipolar_out,
  input wire logic        range_valid_out
);
  logic       wp, rp, sw;
  logic [7:0] pa;
  logic [3:0] st, sp;
  logic [1:0] src;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  assign sw = wp && pa == 8'h8;
  // data phase tracking
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {wp, rp, pa} <= 10'h0;
    end else begin
      wp <= hsel_in && htrans_in[1] && hwrite_in;
      rp <= hsel_in && htrans_in[1] && !hwrite_in;
      pa <= haddr_in[7:0];
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {sp, st, src} <= 10'h0;
    end else if (sw) begin
      {sp, st} <= hwdata_in[7:0];
    end else if (wp && pa == 8'h24) begin
      src <= hwdata_in[1:0];
    end
  end
  chk_scan_load: assert property (sw |=> mux_channel_out == $past(hwdata_in[3:0]))
    else $error("scan load");
  chk_chan_step: assert property (conv_start_out && !sw |=>
    mux_channel_out == (($past(mux_channel_out) == sp) ? st : $past(mux_channel_out) + 4'h1))
    else $error("channel step");
  chk_chan_hold: assert property (!conv_start_out && !sw |=> $stable(mux_channel_out))
    else $error("channel hold");
  chk_soft_trig: assert property (wp && pa == 8'h0 && src == 2'h1 |=> conv_start_out)
    else $error("soft trigger");
  chk_rd_chan: assert property (rp && pa == 8'h8 |-> hrdata_out == {28'h0, mux_channel_out})
    else $error("channel read");
  chk_rd_idle: assert property (!rp |-> hrdata_out == 32'h0)
    else $error("idle rdata");
  chk_code_valid: assert property ($past(rst_n_in) |->
    range_valid_out == (range_code_out < (HIGH_GAIN ? 4'hc : 4'h9))) else $error("valid");
  chk_code_bip: assert property ($past(rst_n_in) |-> range_bipolar_out ==
    (range_valid_out && (range_code_out < 4'h4 || range_code_out > 4'h7))) else $error("bip");
endmodule
bind adc_trigger_range_scan_ctrl scan_ctrl_checker #(.HIGH_GAIN(HIGH_GAIN)) i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hrdata_out(hrdata_out), .conv_start_out(conv_start_out),
  .mux_channel_out(mux_channel_out), .range_code_out(range_code_out),
  .range_bipolar_out(range_bipolar_out), .range_valid_out(range_valid_out));

//--- bench/adc_trigger_range_scan_ctrl_tb.sv
`timescale 1ns/1ns
module adc_trigger_range_scan_ctrl_tb;
  logic        clk_in, rst_n_in, hsel, hwrite, pacer, ext, conv, hrdy;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [3:0]  chan, code, m_chan;
  int          err_count, cmp_count, m_cnt, n;
`define CHK(nm, e, v) begin cmp_count++; if ((v) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, v); end end
  adc_trigger_range_scan_ctrl i_adc_trigger_range_scan_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
    .pacer_tick_in(pacer), .ext_trigger_in(ext), .conv_start_out(conv),
    .mux_channel_out(chan), .range_code_out(code), .range_bipolar_out(),
    .range_valid_out());
  conv_model i_conv_model (.clk_in(clk_in), .conv_start_in(conv), .chan_in(chan),
    .count_out(m_cnt), .chan_out(m_chan));
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    r = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h0);
    `CHK("rdata", e, r)
  endtask
  task pulse(input logic p, input logic x);
    pacer <= p;
    ext <= x;
    @(posedge clk_in);
    pacer <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task t_reset;
    rdchk(32'h8, 32'h0);
    rdchk(32'h28, 32'h0);
  endtask
  task t_scan;
    n = m_cnt;
    wr(32'h24, 8'h1);
    wr(32'h8, 8'h73);
    rdchk(32'h8, 32'h3);
    for (int i = 0; i < 6; i++) begin
      wr(32'h0, 8'(i));
      rdchk(32'h8, (i < 4) ? i + 4 : i - 1);
    end
    `CHK("convs", n + 6, m_cnt)
    `CHK("conv chan", 4'h3, m_chan)
  endtask
  task t_wrap;
    wr(32'h8, 8'h1e);
    for (int i = 0; i < 4; i++) begin
      wr(32'h0, 8'h0);
      rdchk(32'h8, (i < 3) ? (15 + i) % 16 : 14);
    end
  endtask
  task t_range;
    for (int c = 0; c < 16; c++) begin
      wr(32'h8, 8'(c));
      wr(32'h4, 8'hf0 | 8'(15 - c));
      rdchk(32'h8, c);
      rdchk(32'h28, 15 - c);
    end
    wr(32'h8, 8'h50);
    rdchk(32'h28, 32'hf);
    `CHK("code", 4'hf, code)
  endtask
  task t_src;
    n = m_cnt;
    wr(32'h24, 8'h0);
    wr(32'h0, 8'h0);
    pulse(1'b1, 1'b0);
    `CHK("no source", n, m_cnt)
    wr(32'h24, 8'h2);
    wr(32'h0, 8'h0);
    pulse(1'b1, 1'b1);
    `CHK("pacer", n + 1, m_cnt)
    wr(32'h24, 8'h3);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    `CHK("external", n + 2, m_cnt)
    wr(32'h24, 8'hfd);
    wr(32'h0, 8'h0);
    rdchk(32'hc, 32'h0);
    `CHK("soft", n + 3, m_cnt)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    final_report;
  end
  initial begin
    {hsel, hwrite, pacer, ext, rst_n_in} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_scan;
    t_wrap;
    t_range;
    t_src;
    final_report;
  end
endmodule
